//--- design/fpse_regs.vh
// Purpose: Constants for the front panel setting editor
// Assumes: 125 MHz module clock, 32-bit AXI4-Lite register bus
// Notes: Times are given in their own unit; cycle counts derive from them
`ifndef FPSE_REGS_VH
`define FPSE_REGS_VH

// Clock rate in hertz
`define FPSE_CLK_HZ 64'd125000000

// Press timing in milliseconds, inactivity in seconds
`define FPSE_DEB_MS 64'd10
`define FPSE_BACK_MS 64'd300
`define FPSE_FWD_MS 64'd750
`define FPSE_HOLD_MS 64'd1000
`define FPSE_BLINK_MS 64'd250
`define FPSE_TMO_S 64'd300

// Cycle counts, least times rounded up
`define FPSE_MS2CYC(ms) (((ms) * `FPSE_CLK_HZ + 64'd999) / 64'd1000)
`define FPSE_DEB_CYC `FPSE_MS2CYC(`FPSE_DEB_MS)
`define FPSE_BACK_CYC `FPSE_MS2CYC(`FPSE_BACK_MS)
`define FPSE_FWD_CYC `FPSE_MS2CYC(`FPSE_FWD_MS)
`define FPSE_HOLD_CYC `FPSE_MS2CYC(`FPSE_HOLD_MS)
`define FPSE_BLINK_CYC `FPSE_MS2CYC(`FPSE_BLINK_MS)
`define FPSE_TMO_CYC (`FPSE_TMO_S * `FPSE_CLK_HZ)

// Register byte offsets
`define FPSE_OFS_CTRL 8'h00
`define FPSE_OFS_STATUS 8'h04
`define FPSE_OFS_GROUPS 8'h08
`define FPSE_OFS_LIMIT 8'h10
`define FPSE_OFS_SET 8'h20
`define FPSE_LIMIT_MASK 8'hF0
`define FPSE_SET_MASK 8'hE0

// Field positions
`define FPSE_CTRL_BANK 0
`define FPSE_ST_BANK 0
`define FPSE_ST_EDIT 1
`define FPSE_ST_ON 2
`define FPSE_ST_REJECT 3
`define FPSE_ST_POS 4

// Reset values
`define FPSE_SET_RST 14'h0100
`define FPSE_LIM_RST 24'h999000
`define FPSE_GRP_RST 8'h00

`endif

//--- design/fpse_btn.v
// Purpose: Debounce two push buttons and classify each press
// Assumes: Button pins are asynchronous and active high
// Notes: Event outputs are one-cycle pulses on aclk
`timescale 1ns/100ps
`include "fpse_regs.vh"

module fpse_btn #(
  parameter [63:0] DEB_CYC = `FPSE_DEB_CYC,
  parameter [63:0] BACK_CYC = `FPSE_BACK_CYC,
  parameter [63:0] FWD_CYC = `FPSE_FWD_CYC,
  parameter [63:0] HOLD_CYC = `FPSE_HOLD_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire step_btn,
  input wire prog_btn,
  output wire step_tap,
  output wire step_fwd,
  output wire step_back,
  output wire prog_tap,
  output wire prog_hold,
  output wire both_press,
  output wire any_press
);
  wire [1:0] pin = {prog_btn, step_btn}; // Bit 0 step, bit 1 program
  wire [1:0] lvl; // Debounced levels
  wire [1:0] rise; // Debounced press edges
  wire [1:0] fall; // Debounced release edges
  wire [55:0] dur; // Press durations, 28 bits each
  reg both_q; // Both buttons seen together
  reg hold_q; // Program hold already reported

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_btn
      reg s1_q; // Synchroniser first stage
      reg s2_q; // Synchroniser second stage
      reg lvl_q; // Debounced level
      reg prev_q; // Level one cycle ago
      reg [27:0] deb_q; // Debounce stability count
      reg [27:0] dur_q; // Press length count
      // Sync, debounce and time each press
      always @(posedge aclk) begin
        if (!aresetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          lvl_q <= 1'b0;
          prev_q <= 1'b0;
          deb_q <= 28'h0000000;
          dur_q <= 28'h0000000;
        end else begin
          s1_q <= pin[i];
          s2_q <= s1_q;
          prev_q <= lvl_q;
          // Level only moves after a stable run, so contact bounce is lost
          if (s2_q != lvl_q) begin
            if ({36'h0, deb_q} >= DEB_CYC - 64'd1) begin
              lvl_q <= s2_q;
              deb_q <= 28'h0000000;
            end else begin
              deb_q <= deb_q + 28'h0000001;
            end
          end else begin
            deb_q <= 28'h0000000;
          end
          // Duration saturates so a stuck button cannot wrap
          if (lvl_q && !prev_q) begin
            dur_q <= 28'h0000000;
          end else if (lvl_q && dur_q != 28'hFFFFFFF) begin
            dur_q <= dur_q + 28'h0000001;
          end
        end
      end
      assign lvl[i] = lvl_q;
      assign rise[i] = lvl_q & ~prev_q;
      assign fall[i] = ~lvl_q & prev_q;
      assign dur[i*28 +: 28] = dur_q;
    end
  endgenerate

  // Track joint presses and a reported program hold
  always @(posedge aclk) begin
    if (!aresetn) begin
      both_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      if (&lvl && |rise) begin
        both_q <= 1'b1;
      end else if (~|lvl) begin
        both_q <= 1'b0;
      end
      if (prog_hold) begin
        hold_q <= 1'b1;
      end else if (!lvl[1]) begin
        hold_q <= 1'b0;
      end
    end
  end

  // Joint press reported once; its releases are swallowed
  assign both_press = &lvl & |rise & ~both_q;
  assign any_press = |rise;
  assign step_tap = fall[0] & ~both_q;
  // Long release goes forward, a half-second one goes back
  assign step_fwd = step_tap & ({36'h0, dur[27:0]} >= FWD_CYC);
  assign step_back = step_tap & ({36'h0, dur[27:0]} >= BACK_CYC) &
                     ({36'h0, dur[27:0]} < FWD_CYC);
  assign prog_hold = lvl[1] & ~both_q & ~hold_q &
                     ({36'h0, dur[55:28]} == HOLD_CYC - 64'd1);
  assign prog_tap = fall[1] & ~both_q & ~hold_q;
endmodule // fpse_btn

//--- design/fpse_top.v
// Purpose: Front panel setting editor with display and bank choice
// Assumes: Single 125 MHz clock, synchronous active-low reset
// Notes: Menu positions 0-3 settings, 4-6 switch groups, 7 bank
// Function
// - Group checksum is weighted sum of switches
// - Edit mode changes each group switch singly
// - Group indicator lit while its checksum shows
// - Bank switches by serial, input or panel
// - Program hold enters edit, whole display flashes
// - Step press changes the flashing digit
// - Decimal point step, then whole display flashes
// - Store only on joint step and program
// - Leaving edit without store keeps old value
// - Out-of-limit value rejected on store
// - Program hold in edit returns to menu
// - Five-minute inactivity timer restarts on press
// - Timeout darkens display, returns to normal
// - One-second step forward, half-second backward
// - One red code digit, three green value digits
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
`include "fpse_regs.vh"

module fpse_top #(
  parameter [63:0] DEB_CYC = `FPSE_DEB_CYC,
  parameter [63:0] BACK_CYC = `FPSE_BACK_CYC,
  parameter [63:0] FWD_CYC = `FPSE_FWD_CYC,
  parameter [63:0] HOLD_CYC = `FPSE_HOLD_CYC,
  parameter [63:0] BLINK_CYC = `FPSE_BLINK_CYC,
  parameter [63:0] TMO_CYC = `FPSE_TMO_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire step_btn,
  input wire prog_btn,
  input wire bank_input_one,
  input wire bank_input_two,
  input wire remote_reset_input,
  output reg [3:0] disp_red,
  output reg [11:0] disp_green,
  output reg [1:0] disp_dp,
  output reg [3:0] disp_blank,
  output reg disp_dp_blank,
  output reg [3:0] led_setting,
  output reg [2:0] led_group,
  output reg bank_second
);
  localparam ST_DARK = 2'd0; // Normal state, display off
  localparam ST_MENU = 2'd1; // Browsing positions
  localparam ST_WHOLE = 2'd2; // Edit, whole display flashing
  localparam ST_DIGIT = 2'd3; // Edit, one item flashing

  wire step_tap, step_fwd, step_back, prog_tap, prog_hold;
  wire both_press, any_press;
  reg [1:0] st_q; // Panel state
  reg [2:0] pos_q; // Menu position
  reg [2:0] cur_q; // Edit cursor
  reg [13:0] edit_q; // Working copy: dp position and three digits
  reg [13:0] mem_q [0:7]; // Settings, bank in the top index bit
  reg [7:0] grp_q [0:2]; // Function, blocking, output route groups
  reg [23:0] lim_q [0:3]; // Per-setting {high, low} limits
  reg bank_q; // Bank chosen by serial command or panel
  reg reject_q; // Last store was out of limits
  reg [35:0] tmo_q; // Inactivity count
  reg [27:0] blink_q; // Flash phase count
  reg blink_on_q; // Flash phase
  reg [2:0] bs1_q, bs2_q; // Bank input synchroniser
  reg aw_full_q, w_full_q; // Write halves held
  reg [7:0] aw_addr_q; // Held write address
  reg [31:0] w_data_q; // Held write data
  reg [3:0] w_strb_q; // Held strobes
  integer k;

  fpse_btn #(
    .DEB_CYC(DEB_CYC),
    .BACK_CYC(BACK_CYC),
    .FWD_CYC(FWD_CYC),
    .HOLD_CYC(HOLD_CYC)
  ) u_btn (
    .aclk(aclk),
    .aresetn(aresetn),
    .step_btn(step_btn),
    .prog_btn(prog_btn),
    .step_tap(step_tap),
    .step_fwd(step_fwd),
    .step_back(step_back),
    .prog_tap(prog_tap),
    .prog_hold(prog_hold),
    .both_press(both_press),
    .any_press(any_press)
  );

  // Any external input forces the second bank; with none, bank_q decides
  wire bank_act = (|bs2_q) | bank_q;
  wire is_set = ~pos_q[2]; // Positions 0-3 hold settings
  wire is_bank = (pos_q == 3'h7);
  wire editing = st_q[1];
  wire [2:0] sel = {bank_act, pos_q[1:0]};
  wire [23:0] lim_cur = lim_q[pos_q[1:0]];
  wire [3:0] cur_dig = edit_q[{cur_q[1:0], 2'b00} +: 4];
  // Digits, then the decimal point for settings
  wire [2:0] cur_last = is_set ? 3'h3 : (is_bank ? 3'h0 : 3'h7);
  wire in_lim = (edit_q[11:0] >= lim_cur[11:0]) &&
                (edit_q[11:0] <= lim_cur[23:12]);
  wire wr_go = aw_full_q & w_full_q;
  wire [7:0] wa = aw_addr_q;
  wire wa_lim = ((wa & `FPSE_LIMIT_MASK) == `FPSE_OFS_LIMIT);
  wire wa_ok = (wa[1:0] == 2'b00) && (wa == `FPSE_OFS_CTRL ||
               wa == `FPSE_OFS_STATUS || wa == `FPSE_OFS_GROUPS || wa_lim ||
               (wa & `FPSE_SET_MASK) == `FPSE_OFS_SET);

  assign awready = ~aw_full_q & ~bvalid;
  assign wready = ~w_full_q & ~bvalid;
  assign arready = ~rvalid;

  // Binary byte to three decimal digits
  function [11:0] fpse_bcd;
    input [7:0] v;
    reg [7:0] h, t, o;
    begin
      h = v / 8'd100;
      t = (v % 8'd100) / 8'd10;
      o = v % 8'd10;
      fpse_bcd = {h[3:0], t[3:0], o[3:0]};
    end
  endfunction

  // Merge write data into a word under byte strobes
  function [31:0] fpse_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      for (b = 0; b < 4; b = b + 1)
        fpse_merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  reg [31:0] m_ctrl, m_grp, m_lim; // Merged write words
  always @* begin
    m_ctrl = fpse_merge({31'h0, bank_q}, w_data_q, w_strb_q);
    m_grp = fpse_merge({8'h00, grp_q[2], grp_q[1], grp_q[0]},
                       w_data_q, w_strb_q);
    m_lim = fpse_merge({4'h0, lim_q[wa[3:2]][23:12],
                        4'h0, lim_q[wa[3:2]][11:0]}, w_data_q, w_strb_q);
  end

  // Bus writes, panel state machine, stored values and timeout
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_DARK;
      pos_q <= 3'h0;
      cur_q <= 3'h0;
      edit_q <= 14'h0000;
      bank_q <= 1'b0;
      reject_q <= 1'b0;
      tmo_q <= 36'h000000000;
      bs1_q <= 3'h0;
      bs2_q <= 3'h0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      for (k = 0; k < 8; k = k + 1)
        mem_q[k] <= `FPSE_SET_RST;
      for (k = 0; k < 4; k = k + 1)
        lim_q[k] <= `FPSE_LIM_RST;
      for (k = 0; k < 3; k = k + 1)
        grp_q[k] <= `FPSE_GRP_RST;
    end else begin
      bs1_q <= {remote_reset_input, bank_input_two, bank_input_one};
      bs2_q <= bs1_q;
      // Write channel halves may arrive in either order
      if (awvalid && awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wa_ok ? 2'b00 : 2'b10;
        // Serial bank command; read-only words are ignored
        if (wa == `FPSE_OFS_CTRL)
          bank_q <= m_ctrl[`FPSE_CTRL_BANK];
        if (wa == `FPSE_OFS_GROUPS) begin
          grp_q[0] <= m_grp[7:0];
          grp_q[1] <= m_grp[15:8];
          grp_q[2] <= m_grp[23:16];
        end
        if (wa_lim)
          lim_q[wa[3:2]] <= {m_lim[27:16], m_lim[11:0]};
      end
      // Every press restarts the five-minute timer
      if (any_press || st_q == ST_DARK)
        tmo_q <= 36'h000000000;
      else
        tmo_q <= tmo_q + 36'h000000001;
      if (st_q != ST_DARK && {28'h0, tmo_q} >= TMO_CYC - 64'd1) begin
        st_q <= ST_DARK; // Abandon any routine, unsaved edit lost
        pos_q <= 3'h0;
      end else begin
        case (st_q)
          ST_DARK: begin
            if (step_tap)
              st_q <= ST_MENU;
          end
          ST_MENU: begin
            if (step_fwd)
              pos_q <= pos_q + 3'h1;
            else if (step_back)
              pos_q <= pos_q - 3'h1;
            else if (prog_hold) begin
              // Start from the unaltered value
              st_q <= ST_WHOLE;
              reject_q <= 1'b0;
              if (is_set)
                edit_q <= mem_q[sel];
              else if (is_bank)
                edit_q <= {13'h0000, bank_q};
              else
                edit_q <= {6'h00, grp_q[pos_q[1:0]]};
            end
          end
          ST_WHOLE, ST_DIGIT: begin
            if (both_press) begin
              // Commit only on the joint press
              st_q <= ST_MENU;
              if (is_set) begin
                if (in_lim)
                  mem_q[sel] <= edit_q;
                else
                  reject_q <= 1'b1; // Old value kept
              end else if (is_bank)
                bank_q <= edit_q[0]; // Panel bank choice
              else
                grp_q[pos_q[1:0]] <= edit_q[7:0];
            end else if (prog_hold) begin
              st_q <= ST_MENU; // Edit copy dropped
            end else if (prog_tap) begin
              if (st_q == ST_WHOLE) begin
                st_q <= ST_DIGIT; // Rightmost item first
                cur_q <= 3'h0;
              end else if (cur_q == cur_last) begin
                st_q <= ST_WHOLE; // Back to awaiting store
              end else begin
                cur_q <= cur_q + 3'h1;
              end
            end else if (step_tap && st_q == ST_DIGIT) begin
              if (!is_set)
                edit_q[cur_q] <= ~edit_q[cur_q]; // One switch
              else if (cur_q == 3'h3)
                edit_q[13:12] <= (edit_q[13:12] == 2'h2) ? 2'h0 :
                                 edit_q[13:12] + 2'h1;
              else
                edit_q[{cur_q[1:0], 2'b00} +: 4] <=
                  (cur_dig == 4'h9) ? 4'h0 : cur_dig + 4'h1;
            end
          end
          default: st_q <= ST_DARK;
        endcase
      end
    end
  end

  // Read answer one cycle after the address is taken
  reg [31:0] rd_d;
  reg rd_ok;
  always @* begin
    rd_d = 32'h00000000;
    rd_ok = (araddr[1:0] == 2'b00);
    if (araddr == `FPSE_OFS_CTRL)
      rd_d = {31'h0, bank_q};
    else if (araddr == `FPSE_OFS_STATUS)
      rd_d = {25'h0, pos_q, reject_q, st_q != ST_DARK, editing, bank_act};
    else if (araddr == `FPSE_OFS_GROUPS)
      rd_d = {8'h00, grp_q[2], grp_q[1], grp_q[0]};
    else if ((araddr & `FPSE_LIMIT_MASK) == `FPSE_OFS_LIMIT)
      rd_d = {4'h0, lim_q[araddr[3:2]][23:12],
              4'h0, lim_q[araddr[3:2]][11:0]};
    else if ((araddr & `FPSE_SET_MASK) == `FPSE_OFS_SET)
      rd_d = {18'h0, mem_q[araddr[4:2]]};
    else
      rd_ok = 1'b0;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'b00;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_ok ? rd_d : 32'h00000000;
      rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Display content; flash mask bit 4 is the decimal point
  reg [3:0] red_d;
  reg [11:0] grn_d;
  reg [1:0] dp_d;
  reg [4:0] fl_d;
  reg [7:0] byte_d;
  always @* begin
    red_d = {1'b0, pos_q} + 4'h1; // Red code digit
    grn_d = 12'h000;
    dp_d = 2'h0;
    fl_d = 5'h00;
    byte_d = editing ? edit_q[7:0] : grp_q[pos_q[1:0]];
    if (is_set) begin
      grn_d = editing ? edit_q[11:0] : mem_q[sel][11:0];
      dp_d = editing ? edit_q[13:12] : mem_q[sel][13:12];
    end else if (is_bank) begin
      grn_d = {11'h000, editing ? edit_q[0] : bank_act};
    end else if (st_q == ST_DIGIT) begin
      red_d = {1'b0, cur_q} + 4'h1; // Switch number and its position
      grn_d = {11'h000, byte_d[cur_q]};
    end else begin
      grn_d = fpse_bcd(byte_d); // Weight 2^(n-1) sum is the byte
    end
    if (st_q == ST_WHOLE)
      fl_d = 5'h1F;
    else if (st_q == ST_DIGIT && is_set)
      fl_d = (cur_q == 3'h3) ? 5'h10 : (5'h01 << cur_q[1:0]);
    else if (st_q == ST_DIGIT)
      fl_d = 5'h08; // The red digit names the switch in hand
  end

  // Registered display, indicators and bank output
  always @(posedge aclk) begin
    if (!aresetn) begin
      blink_q <= 28'h0000000;
      blink_on_q <= 1'b0;
      disp_red <= 4'h0;
      disp_green <= 12'h000;
      disp_dp <= 2'h0;
      disp_blank <= 4'hF; // Dark after reset
      disp_dp_blank <= 1'b1;
      led_setting <= 4'h0;
      led_group <= 3'h0;
      bank_second <= 1'b0;
    end else begin
      if ({36'h0, blink_q} >= BLINK_CYC - 64'd1) begin
        blink_q <= 28'h0000000;
        blink_on_q <= ~blink_on_q;
      end else begin
        blink_q <= blink_q + 28'h0000001;
      end
      disp_red <= red_d;
      disp_green <= grn_d;
      disp_dp <= dp_d;
      if (st_q == ST_DARK) begin
        disp_blank <= 4'hF;
        disp_dp_blank <= 1'b1;
        led_setting <= 4'h0;
        led_group <= 3'h0;
      end else begin
        disp_blank <= fl_d[3:0] & {4{blink_on_q}};
        disp_dp_blank <= fl_d[4] & blink_on_q;
        led_setting <= is_set ? (4'h1 << pos_q[1:0]) : 4'h0;
        // Group lamp only while its checksum is shown
        led_group <= (!is_set && !is_bank && st_q != ST_DIGIT) ?
                     (3'h1 << pos_q[1:0]) : 3'h0;
      end
      bank_second <= bank_act;
    end
  end
endmodule // fpse_top

//--- test/fpse_panel.sv
// Purpose: Operator push buttons at the front panel
// Assumes: Buttons read high while pressed
// Notes: A released button falls back to its pull-down level
`timescale 1ns/100ps

module fpse_panel (
  input wire aclk,
  output logic step_btn,
  output logic prog_btn
);
  // Both buttons released at power-up
  initial begin
    step_btn = 1'b0;
    prog_btn = 1'b0;
  end

  // Press the chosen buttons for n edges, then let the display settle
  task automatic press(input logic s, input logic p, input int n);
    @(posedge aclk);
    step_btn <= s;
    prog_btn <= p;
    repeat (n) @(posedge aclk);
    step_btn <= 1'b0;
    prog_btn <= 1'b0;
    repeat (20) @(posedge aclk);
  endtask
endmodule // fpse_panel

//--- test/fpse_checker.sv
// Purpose: Bus and panel assertions on the editor top
// Assumes: Short counts chosen by the bench
// Notes: Idle bound leaves room for sync and debounce delay
`timescale 1ns/100ps

module fpse_checker #(
  parameter [63:0] TMO_CYC = 64'd400
) (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  input wire rready,
  input wire step_btn,
  input wire prog_btn,
  input wire bank_input_one,
  input wire [3:0] disp_red,
  input wire [3:0] disp_blank,
  input wire [2:0] led_group,
  input wire bank_second
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [15:0] idle_q; // Edges since either button was last down

  // Idle counter, saturating so it never wraps back under the bound
  always_ff @(posedge aclk) begin
    if (!aresetn || step_btn || prog_btn) idle_q <= 16'h0;
    else if (idle_q != 16'hFFFF) idle_q <= idle_q + 16'h1;
  end

  sequence wr_taken_s;
    awvalid && awready && wvalid && wready;
  endsequence

  rst_dark_a: assert property ($rose(aresetn) |->
    disp_blank == 4'hF && !bank_second && led_group == 3'h0)
    else $error("not dark after reset");
  wr_answer_a: assert property (wr_taken_s |-> ##2 bvalid)
    else $error("write answer late");
  wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  rd_err_a: assert property (arvalid && arready && araddr == 8'h40 |=>
    rresp == 2'h2 && rdata == 32'h0) else $error("unmapped read not refused");
  grp_led_a: assert property (led_group[0] |-> disp_red == 4'h5)
    else $error("group indicator without its checksum");
  bank_force_a: assert property (
    bank_input_one [*6] |-> bank_second) else $error("bank input ignored");
  idle_dark_a: assert property (idle_q > TMO_CYC + 64'd30 |->
    disp_blank == 4'hF) else $error("display lit after idle time");
endmodule // fpse_checker

bind fpse_top fpse_checker #(.TMO_CYC(TMO_CYC)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .step_btn(step_btn), .prog_btn(prog_btn), .bank_input_one(bank_input_one),
  .disp_red(disp_red), .disp_blank(disp_blank), .led_group(led_group),
  .bank_second(bank_second));

//--- test/tb_top.sv
// Purpose: Self-checking bench for the front panel setting editor
// Assumes: Short press and timeout counts for simulation
// Notes: Bus handshakes are sampled mid-cycle and acted on at the edge
`timescale 1ns/100ps

module tb_top;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, arready;
  logic bvalid, rvalid, step_btn, prog_btn, bank_second;
  logic [1:0] bresp, rresp, r;
  logic bank_input_one = 1'b0, bank_input_two = 1'b0;
  logic remote_reset_input = 1'b0;
  logic [3:0] disp_red, disp_blank, led_setting;
  logic [11:0] disp_green;
  logic [1:0] disp_dp;
  logic disp_dp_blank;
  logic [2:0] led_group;
  int err_total = 0, checks = 0;

  always #4 aclk = ~aclk; // 125 MHz

  fpse_panel u_panel (.aclk(aclk), .step_btn(step_btn), .prog_btn(prog_btn));

  fpse_top #(.DEB_CYC(64'd4), .BACK_CYC(64'd20), .FWD_CYC(64'd40),
    .HOLD_CYC(64'd60), .BLINK_CYC(64'd8), .TMO_CYC(64'd400)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .step_btn(step_btn),
    .prog_btn(prog_btn), .bank_input_one(bank_input_one),
    .bank_input_two(bank_input_two), .remote_reset_input(remote_reset_input),
    .disp_red(disp_red), .disp_green(disp_green), .disp_dp(disp_dp),
    .disp_blank(disp_blank), .disp_dp_blank(disp_dp_blank),
    .led_setting(led_setting), .led_group(led_group),
    .bank_second(bank_second));

  // Verdict, reached from the main sequence or from a timeout
  task close_out;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Case-equal compare so an unknown never matches
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One write: both halves offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    bit ta, tw, dn;
    dn = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= v; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int i = 0; i < 50 && !dn; i++) begin
      @(negedge aclk);
      ta = awvalid && awready; tw = wvalid && wready; dn = bvalid; r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    // One more edge so registered outputs of the write have settled
    @(posedge aclk);
    if (!dn) begin err_total++; close_out(); end
  endtask

  // One read: address held until taken, data kept at the answering edge
  task automatic axi_rd(input logic [7:0] a);
    bit ta, dn;
    dn = 1'b0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int i = 0; i < 50 && !dn; i++) begin
      @(negedge aclk);
      ta = arvalid && arready; dn = rvalid; d = rdata; r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!dn) begin err_total++; close_out(); end
  endtask

  // Hold program to edit, tap to rightmost digit, one step adds one
  task automatic edit_plus_one;
    u_panel.press(1'b0, 1'b1, 70);
    u_panel.press(1'b0, 1'b1, 8);
    u_panel.press(1'b1, 1'b0, 8);
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(8'h04); chk(d, 32'h0);
    chk(32'(bank_second), 32'h0);
    axi_rd(8'h40); chk(32'(r), 32'h2);
    axi_wr(8'h40, 32'h1); chk(32'(r), 32'h2);
    $display("test reset done");
    axi_wr(8'h00, 32'h1); chk(32'(bank_second), 32'h1);
    axi_wr(8'h00, 32'h0);
    bank_input_one <= 1'b1;
    repeat (10) @(posedge aclk);
    chk(32'(bank_second), 32'h1);
    bank_input_one <= 1'b0;
    bank_input_two <= 1'b1;
    repeat (10) @(posedge aclk);
    chk(32'(bank_second), 32'h1);
    bank_input_two <= 1'b0;
    remote_reset_input <= 1'b1;
    repeat (10) @(posedge aclk);
    chk(32'(bank_second), 32'h1);
    remote_reset_input <= 1'b0;
    repeat (10) @(posedge aclk);
    chk(32'(bank_second), 32'h0);
    $display("test bank done");
    u_panel.press(1'b1, 1'b0, 8); // Lights the first setting
    chk(32'(disp_red), 32'h1); chk(32'(disp_green), 32'h100);
    axi_wr(8'h10, 32'h0101_0000); // Upper limit 101
    edit_plus_one();
    chk(32'(disp_green), 32'h101);
    axi_rd(8'h04); chk(32'(d[1]), 32'h1);
    u_panel.press(1'b1, 1'b1, 8); // Joint press stores
    axi_rd(8'h20); chk(d, 32'h101);
    edit_plus_one();
    u_panel.press(1'b1, 1'b1, 8); // Store 102, above the limit
    axi_rd(8'h20); chk(d, 32'h101);
    axi_rd(8'h04); chk(32'(d[3]), 32'h1);
    edit_plus_one();
    u_panel.press(1'b0, 1'b1, 70); // Leave without storing
    axi_rd(8'h20); chk(d, 32'h101);
    axi_rd(8'h04); chk(32'(d[1]), 32'h0);
    $display("test edit done");
    axi_wr(8'h08, 32'h5D); // Switches 1,3,4,5,7 on
    repeat (4) u_panel.press(1'b1, 1'b0, 45);
    chk(32'(disp_green), 32'h093);
    chk(32'(led_group), 32'h1);
    edit_plus_one(); // Flips switch 1 of the function group
    u_panel.press(1'b1, 1'b1, 8);
    chk(32'(disp_green), 32'h092);
    axi_rd(8'h08); chk(d, 32'h5C);
    u_panel.press(1'b1, 1'b0, 25); // Half-length press steps back
    chk(32'(disp_red), 32'h4);
    chk(32'(led_group), 32'h0);
    $display("test groups done");
    repeat (450) @(posedge aclk);
    chk(32'(disp_blank), 32'hF);
    $display("test timeout done");
    close_out();
  end
endmodule // tb_top
